// ===== inc/debug_probe_map.vh
// Purpose: constants for the probe-backed debug memory access block
// Assumes: 32-bit addresses and data, TAP instruction register of five bits
// Notes: included by the access block design file, the probe model and the bench
// Notes on behaviour
// R1 - shifted zero fast flag completes pending access
// R2 - fast success needs pending and fast-area address
// R3 - completion request shifts out success flag
// R4 - shifted one only reports, changes nothing
// R5 - fast-area access stalls cpu while pending
// R6 - download writes shifted word, returns previous data
// R7 - upload shifts out store word, valid on success
// R8 - reset-occurred bit ignored for fast completion
// R9 - route only in segment, enabled, debug mode
// R10 - segment-select bit also gates probe routing
// R11 - probe vector exception fetches at vector address
// R12 - pending ends by probe zero or reset
// R13 - fetch/load latches address, pending, read, size
// R14 - store latches address, data, pending, write, size
// R15 - probe polls pending, direction, then address
// R16 - probe fills data then clears pending
// R17 - probe takes store data then clears pending
// R18 - completed fetch loads instruction, advances pc
// R19 - pending zero means access complete
// R20 - probe and external accesses are serialised
// R21 - pending is bit 18, write-zero, resets zero
// R22 - probe zero-fills unused read bytes
// R23 - bit 15 enables probe memory handling
// R24 - fast completion releases cpu like probe clear
`ifndef DEBUG_PROBE_MAP_VH
`define DEBUG_PROBE_MAP_VH
// tap instruction codes
`define IR_LEN 5
`define IR_CAPTURE 5'h01
`define INS_ADDRESS 5'h08
`define INS_DATA 5'h09
`define INS_CONTROL 5'h0a
`define INS_FASTDATA 5'h0e
`define INS_BYPASS 5'h1f
// control register field positions
`define CTL_DM 3
`define CTL_VECTOR 14
`define CTL_ENABLE 15
`define CTL_PENDING 18
`define CTL_DIR 19
`define CTL_SIZE_LO 29
`define CTL_SIZE_HI 30
// control register reset values
`define ENABLE_RST 1'b0
`define VECTOR_RST 1'b0
// address windows
`define SEG_BASE 32'hff200000
`define SEG_LAST 32'hff2fffff
`define FAST_BASE 32'hff200000
`define FAST_LAST 32'hff20000f
`define DEBUG_VECTOR 32'hff200200
// misc values
`define SIZE_WORD 2'h3
`define PC_STEP 32'h00000004
// shift chain msb positions
`define MSB_FAST 6'd32
`define MSB_WORD 6'd31
`define MSB_BYP 6'd0
`endif

// ===== design/pin_sync.v
// Purpose: two-flop synchroniser for pins from outside the clock domain
// Assumes: each bit is an independent level
// Notes: first stage feeds only the second stage
`timescale 1ns/1ns
module pin_sync #(
  parameter WIDTH = 3
) (
  input wire clk,
  input wire rst,
  input wire [WIDTH-1:0] din,
  output reg [WIDTH-1:0] dout
);
  reg [WIDTH-1:0] meta_reg; // first stage, read by second only

  ////////////////////////////////////////////////////////////////
  // two stages, reset to zero
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      meta_reg <= {WIDTH{1'b0}};
      dout <= {WIDTH{1'b0}};
    end else begin
      meta_reg <= din;
      dout <= meta_reg;
    end
  end
endmodule

// ===== design/tap_fsm.v
// Purpose: sixteen-state test access port controller
// Assumes: step is a one-cycle pulse on each rising test clock edge
// Notes: outputs are decoded from the current state
`timescale 1ns/1ns
module tap_fsm (
  input wire clk,
  input wire rst,
  input wire step,
  input wire tms,
  output wire in_reset,
  output wire capture_dr,
  output wire shift_dr,
  output wire update_dr,
  output wire capture_ir,
  output wire shift_ir,
  output wire update_ir
);
  localparam RESET = 4'd0;
  localparam IDLE = 4'd1;
  localparam SEL_DR = 4'd2;
  localparam CAP_DR = 4'd3;
  localparam SH_DR = 4'd4;
  localparam EX1_DR = 4'd5;
  localparam PAU_DR = 4'd6;
  localparam EX2_DR = 4'd7;
  localparam UPD_DR = 4'd8;
  localparam SEL_IR = 4'd9;
  localparam CAP_IR = 4'd10;
  localparam SH_IR = 4'd11;
  localparam EX1_IR = 4'd12;
  localparam PAU_IR = 4'd13;
  localparam EX2_IR = 4'd14;
  localparam UPD_IR = 4'd15;

  reg [3:0] state_reg; // current controller state
  reg [3:0] state_next; // state after next edge

  ////////////////////////////////////////////////////////////////
  // next state from tms
  always @* begin
    case (state_reg)
      RESET: state_next = tms ? RESET : IDLE;
      IDLE: state_next = tms ? SEL_DR : IDLE;
      SEL_DR: state_next = tms ? SEL_IR : CAP_DR;
      CAP_DR: state_next = tms ? EX1_DR : SH_DR;
      SH_DR: state_next = tms ? EX1_DR : SH_DR;
      EX1_DR: state_next = tms ? UPD_DR : PAU_DR;
      PAU_DR: state_next = tms ? EX2_DR : PAU_DR;
      EX2_DR: state_next = tms ? UPD_DR : SH_DR;
      UPD_DR: state_next = tms ? SEL_DR : IDLE;
      SEL_IR: state_next = tms ? RESET : CAP_IR;
      CAP_IR: state_next = tms ? EX1_IR : SH_IR;
      SH_IR: state_next = tms ? EX1_IR : SH_IR;
      EX1_IR: state_next = tms ? UPD_IR : PAU_IR;
      PAU_IR: state_next = tms ? EX2_IR : PAU_IR;
      EX2_IR: state_next = tms ? UPD_IR : SH_IR;
      UPD_IR: state_next = tms ? SEL_DR : IDLE;
      default: state_next = RESET;
    endcase
  end

  ////////////////////////////////////////////////////////////////
  // state advances only on a test clock rise
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      state_reg <= RESET;
    end else if (step) begin
      state_reg <= state_next;
    end
  end

  assign in_reset = (state_reg == RESET);
  assign capture_dr = (state_reg == CAP_DR);
  assign shift_dr = (state_reg == SH_DR);
  assign update_dr = (state_reg == UPD_DR);
  assign capture_ir = (state_reg == CAP_IR);
  assign shift_ir = (state_reg == SH_IR);
  assign update_ir = (state_reg == UPD_IR);
endmodule

// ===== design/debug_probe_memory_access.v
// Purpose: cpu accesses to the probe memory segment served over the test port
// Assumes: cpu_req is held high until cpu_done; tck slower than ref_clk / 4
// Notes: tap actions are taken on the rising test clock edge seen in ref_clk; tdo changes on the falling edge
`timescale 1ns/1ns
`include "debug_probe_map.vh"
module debug_probe_memory_access (
  input wire ref_clk,
  input wire rst,
  input wire tck,
  input wire tms,
  input wire tdi,
  output reg tdo,
  input wire cpu_req,
  input wire [31:0] cpu_addr,
  input wire cpu_write,
  input wire cpu_fetch,
  input wire [1:0] cpu_size,
  input wire [31:0] cpu_wdata,
  input wire debug_exception,
  input wire soft_reset,
  input wire debug_mode_flag,
  input wire load_store_segment_select,
  input wire ext_bus_idle,
  output reg cpu_stall,
  output reg cpu_done,
  output reg [31:0] cpu_rdata,
  output reg [31:0] fetch_instr,
  output reg [31:0] fetch_pc,
  output reg ext_bus_hold,
  output reg probe_memory_enable,
  output reg probe_vector_select
);
  localparam ST_IDLE = 2'd0;
  localparam ST_PEND = 2'd1;
  localparam ST_DONE = 2'd2;

  wire [2:0] pins_s; // synchronised tck, tms, tdi
  wire tck_s; // synchronised test clock
  wire tms_s; // synchronised mode select
  wire tdi_s; // synchronised data in
  reg tck_prev_reg; // last sampled test clock
  wire tck_rise; // rising test clock edge
  wire tck_fall; // falling test clock edge
  wire tap_reset; // controller in reset state
  wire cap_dr; // capture data chain
  wire sh_dr; // shift data chain
  wire up_dr; // update data chain
  wire cap_ir; // capture instruction
  wire sh_ir; // shift instruction
  wire up_ir; // update instruction

  reg [4:0] ir_sh_reg; // instruction shift chain
  reg [4:0] instr_reg; // active instruction
  reg [32:0] dr_sh_reg; // data shift chain, fast flag at bit 0
  reg [32:0] dr_sh_next; // chain after one shift
  reg [5:0] dr_msb; // chain input position
  reg fast_ok_reg; // success flag shown at capture

  reg [1:0] state_reg; // cpu access state
  reg [1:0] state_next; // next cpu access state
  reg [31:0] addr_reg; // access address register
  reg [31:0] data_reg; // access data register
  reg dir_reg; // access direction bit, 1 = write
  reg [1:0] size_reg; // transfer size field
  reg fetch_reg; // access is an instruction fetch
  reg vec_req_reg; // vector fetch waiting to start
  reg [31:0] ctl_word; // control word as captured

  wire pending; // access pending bit
  wire in_seg; // cpu address in probe segment
  wire probe_hit; // cpu access routed to probe
  wire fast_area; // access address in fast area
  wire fast_possible; // fast completion would succeed
  wire start_cpu; // cpu request starts an access
  wire start_vec; // vector fetch starts an access
  wire probe_clear; // probe wrote zero to pending
  wire fast_clear; // fast completion succeeded
  wire data_write; // data chain loads data register

  ////////////////////////////////////////////////////////////////
  // pin sampling and test clock edges
  pin_sync #(
    .WIDTH(3)
  ) u_sync (
    .clk(ref_clk),
    .rst(rst),
    .din({tck, tms, tdi}),
    .dout(pins_s)
  );

  assign tck_s = pins_s[2];
  assign tms_s = pins_s[1];
  assign tdi_s = pins_s[0];
  assign tck_rise = tck_s & ~tck_prev_reg;
  assign tck_fall = ~tck_s & tck_prev_reg;

  // edge detector history
  always @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      tck_prev_reg <= 1'b0;
    end else begin
      tck_prev_reg <= tck_s;
    end
  end

  tap_fsm u_tap (
    .clk(ref_clk),
    .rst(rst),
    .step(tck_rise),
    .tms(tms_s),
    .in_reset(tap_reset),
    .capture_dr(cap_dr),
    .shift_dr(sh_dr),
    .update_dr(up_dr),
    .capture_ir(cap_ir),
    .shift_ir(sh_ir),
    .update_ir(up_ir)
  );

  ////////////////////////////////////////////////////////////////
  // access decode
  assign pending = (state_reg == ST_PEND);
  assign in_seg = (cpu_addr >= `SEG_BASE) && (cpu_addr <= `SEG_LAST);
  assign probe_hit = in_seg && probe_memory_enable && debug_mode_flag && load_store_segment_select; // R9 R10 R23
  assign fast_area = (addr_reg >= `FAST_BASE) && (addr_reg <= `FAST_LAST);
  assign fast_possible = pending && fast_area; // R2 R8
  // a new probe access waits for the external bus and any pending one
  assign start_vec = (state_reg == ST_IDLE) && vec_req_reg && ext_bus_idle; // R11 R20
  assign start_cpu = (state_reg == ST_IDLE) && !vec_req_reg && cpu_req && probe_hit && !cpu_done
    && ext_bus_idle; // R20

  // pending cleared by a zero written through the control chain
  assign probe_clear = tck_rise && up_dr && (instr_reg == `INS_CONTROL) && pending
    && !dr_sh_reg[`CTL_PENDING]; // R12 R21
  // fast completion needs a zero shifted in and success shown at capture
  assign fast_clear = tck_rise && up_dr && (instr_reg == `INS_FASTDATA) && !dr_sh_reg[0]
    && fast_ok_reg && pending; // R1 R2 R24
  assign data_write = tck_rise && up_dr && (instr_reg == `INS_DATA) && pending && !dir_reg;

  ////////////////////////////////////////////////////////////////
  // control word seen by the probe
  always @* begin
    ctl_word = 32'h00000000;
    ctl_word[`CTL_SIZE_HI:`CTL_SIZE_LO] = size_reg;
    ctl_word[`CTL_DIR] = dir_reg;
    ctl_word[`CTL_PENDING] = pending; // R21
    ctl_word[`CTL_ENABLE] = probe_memory_enable;
    ctl_word[`CTL_VECTOR] = probe_vector_select;
    ctl_word[`CTL_DM] = debug_mode_flag;
  end

  ////////////////////////////////////////////////////////////////
  // data chain input position per instruction
  always @* begin
    case (instr_reg)
      `INS_FASTDATA: dr_msb = `MSB_FAST;
      `INS_ADDRESS: dr_msb = `MSB_WORD;
      `INS_DATA: dr_msb = `MSB_WORD;
      `INS_CONTROL: dr_msb = `MSB_WORD;
      default: dr_msb = `MSB_BYP;
    endcase
    dr_sh_next = {1'b0, dr_sh_reg[32:1]};
    dr_sh_next[dr_msb] = tdi_s;
  end

  ////////////////////////////////////////////////////////////////
  // instruction chain and register
  always @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      ir_sh_reg <= 5'h00;
      instr_reg <= `INS_BYPASS;
    end else if (tap_reset) begin
      instr_reg <= `INS_BYPASS;
    end else if (tck_rise) begin
      if (cap_ir) begin
        ir_sh_reg <= `IR_CAPTURE;
      end else if (sh_ir) begin
        ir_sh_reg <= {tdi_s, ir_sh_reg[4:1]};
      end else if (up_ir) begin
        instr_reg <= ir_sh_reg;
      end
    end
  end

  ////////////////////////////////////////////////////////////////
  // data chain capture and shift
  always @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      dr_sh_reg <= 33'h000000000;
      fast_ok_reg <= 1'b0;
    end else if (tck_rise && cap_dr) begin
      fast_ok_reg <= fast_possible;
      case (instr_reg)
        `INS_ADDRESS: dr_sh_reg <= {1'b0, addr_reg}; // R15
        `INS_DATA: dr_sh_reg <= {1'b0, data_reg}; // R17
        `INS_CONTROL: dr_sh_reg <= {1'b0, ctl_word}; // R15
        // success flag out first, then current data word
        `INS_FASTDATA: dr_sh_reg <= {data_reg, fast_possible}; // R3 R4 R6 R7
        default: dr_sh_reg <= 33'h000000000;
      endcase
    end else if (tck_rise && sh_dr) begin
      dr_sh_reg <= dr_sh_next;
    end
  end

  ////////////////////////////////////////////////////////////////
  // test data out changes on the falling test clock
  always @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      tdo <= 1'b0;
    end else if (tck_fall) begin
      tdo <= sh_ir ? ir_sh_reg[0] : dr_sh_reg[0];
    end
  end

  ////////////////////////////////////////////////////////////////
  // probe-written control bits
  always @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      probe_memory_enable <= `ENABLE_RST;
      probe_vector_select <= `VECTOR_RST;
    end else if (tck_rise && up_dr && (instr_reg == `INS_CONTROL)) begin
      probe_memory_enable <= dr_sh_reg[`CTL_ENABLE]; // R23
      probe_vector_select <= dr_sh_reg[`CTL_VECTOR];
    end
  end

  ////////////////////////////////////////////////////////////////
  // vector fetch request held until it starts or soft_reset clears it
  always @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      vec_req_reg <= 1'b0;
    end else if (soft_reset) begin
      vec_req_reg <= 1'b0;
    end else if (debug_exception && probe_vector_select) begin
      vec_req_reg <= 1'b1; // R11
    end else if (start_vec) begin
      vec_req_reg <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////
  // cpu access state
  always @* begin
    state_next = state_reg;
    case (state_reg)
      ST_IDLE: begin
        if (start_vec || start_cpu) begin
          state_next = ST_PEND; // R13 R14
        end
      end
      ST_PEND: begin
        if (probe_clear || fast_clear) begin
          state_next = ST_DONE; // R12 R19 R24
        end
      end
      ST_DONE: state_next = ST_IDLE;
      default: state_next = ST_IDLE;
    endcase
    if (soft_reset) begin
      state_next = ST_IDLE; // R12
    end
  end

  // state register, stall and bus hold
  always @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      state_reg <= ST_IDLE;
      cpu_stall <= 1'b0;
      ext_bus_hold <= 1'b0;
    end else begin
      state_reg <= state_next;
      // stall while pending or while a routed request waits to start
      cpu_stall <= (state_next == ST_PEND) || (state_next == ST_DONE)
        || (cpu_req && probe_hit && !cpu_done && (state_reg != ST_DONE) && (state_next == ST_IDLE)); // R5
      ext_bus_hold <= (state_next == ST_PEND); // R20
    end
  end

  ////////////////////////////////////////////////////////////////
  // access address, direction, size and kind
  always @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      addr_reg <= 32'h00000000;
      dir_reg <= 1'b0;
      size_reg <= 2'h0;
      fetch_reg <= 1'b0;
    end else if (!soft_reset && start_vec) begin
      addr_reg <= `DEBUG_VECTOR; // R11
      dir_reg <= 1'b0;
      size_reg <= `SIZE_WORD;
      fetch_reg <= 1'b1;
    end else if (!soft_reset && start_cpu) begin
      addr_reg <= cpu_addr; // R13 R14
      dir_reg <= cpu_write;
      size_reg <= cpu_size;
      fetch_reg <= cpu_fetch && !cpu_write;
    end
  end

  ////////////////////////////////////////////////////////////////
  // access data register
  always @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      data_reg <= 32'h00000000;
    end else if (!soft_reset && start_cpu && cpu_write) begin
      data_reg <= cpu_wdata; // R14
    end else if (data_write) begin
      data_reg <= dr_sh_reg[31:0]; // R16 R22
    end else if (fast_clear && !dir_reg) begin
      data_reg <= dr_sh_reg[32:1]; // R6
    end
  end

  ////////////////////////////////////////////////////////////////
  // completion towards the cpu
  always @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      cpu_done <= 1'b0;
      cpu_rdata <= 32'h00000000;
      fetch_instr <= 32'h00000000;
      fetch_pc <= 32'h00000000;
    end else begin
      cpu_done <= (state_reg == ST_DONE) && !soft_reset; // R19
      if (state_reg == ST_DONE) begin
        if (!dir_reg) begin
          cpu_rdata <= data_reg;
        end
        if (fetch_reg) begin
          fetch_instr <= data_reg; // R18
          fetch_pc <= addr_reg + `PC_STEP; // R18
        end
      end
    end
  end
endmodule

// ===== dv/probe_access_checker_assertions.sv
// Purpose: port timing checks
// Assumes: one ref_clk domain
// Notes: bound at the foot
`timescale 1ns/1ns
module probe_access_checker (
  input wire ref_clk,
  input wire rst,
  input wire cpu_req,
  input wire [31:0] cpu_addr,
  input wire debug_exception,
  input wire soft_reset,
  input wire debug_mode_flag,
  input wire load_store_segment_select,
  input wire ext_bus_idle,
  input wire cpu_stall,
  input wire cpu_done,
  input wire [31:0] cpu_rdata,
  input wire [31:0] fetch_instr,
  input wire ext_bus_hold,
  input wire probe_memory_enable,
  input wire probe_vector_select
);
  default clocking dclk @(posedge ref_clk); endclocking
  default disable iff (rst);
  // routed cpu request, vector fetch request
  wire hit = cpu_addr[31:20] == 12'hff2 && probe_memory_enable && debug_mode_flag && load_store_segment_select;
  wire vec = debug_exception && probe_vector_select;
  ////////////////////////////////////////////////////////////////
  AST_ACCEPT: assert property (!cpu_stall && !cpu_done && !soft_reset && ext_bus_idle && cpu_req && hit
    |=> ext_bus_hold && cpu_stall) else $error("access not taken");
  AST_VEC_ACCEPT: assert property (!cpu_stall && !soft_reset && ext_bus_idle && vec |=> ##1 ext_bus_hold)
    else $error("vector not taken");
  AST_ROUTE_CAUSE: assert property ($rose(cpu_stall) |-> $past(cpu_req) && $past(hit) || $past(vec, 2))
    else $error("stray stall");
  AST_HOLD_STALL: assert property (ext_bus_hold |-> cpu_stall)
    else $error("hold without stall");
  AST_HOLD_IDLE: assert property ($rose(ext_bus_hold) |-> $past(ext_bus_idle))
    else $error("start with bus busy");
  AST_DONE_PULSE: assert property (cpu_done |=> !cpu_done)
    else $error("done too long");
  AST_DONE_ENDS: assert property (cpu_done |-> !cpu_stall && !ext_bus_hold && $past(ext_bus_hold, 2))
    else $error("stray done");
  AST_SOFT_ABORT: assert property (soft_reset |=> !ext_bus_hold && !cpu_done)
    else $error("abort failed");
  AST_STALL_FALL: assert property ($fell(cpu_stall) |-> cpu_done || $past(soft_reset))
    else $error("stray stall release");
  AST_RDATA_DONE: assert property ($changed(cpu_rdata) |-> cpu_done)
    else $error("stray read data");
  AST_FETCH_DONE: assert property ($changed(fetch_instr) |-> cpu_done)
    else $error("stray instruction");
endmodule
bind debug_probe_memory_access probe_access_checker u_chk (.*);

// ===== dv/probe_model.sv
// Purpose: debug probe on the test port
// Assumes: 80 ns test clock, still between scans
// Notes: tdo taken before each rise
`timescale 1ns/1ns
`include "debug_probe_map.vh"
module probe_model (
  output reg tck,
  output reg tms,
  output reg tdi,
  input wire tdo
);
  reg [31:0] keep_bits = 32'h0; // enable and vector bits
  reg [32:0] so = 33'h0; // last chain shifted out
  reg [31:0] wr_word = 32'h0; // probe memory word from last store
  initial begin
    tck = 1'b0;
    tms = 1'b1;
    tdi = 1'b0;
  end
  ////////////////////////////////////////////////////////////////////////////////
  // one test clock; data flips after the rise
  task step(input m, input d, output o);
    begin
      tms = m;
      tdi = d;
      #40;
      o = tdo;
      tck = 1'b1;
      #30;
      tdi = ~d;
      #10;
      tck = 1'b0;
    end
  endtask
  // capture, shift n bits lsb first, update
  task scan(input isir, input integer n, input [32:0] din);
    integer i;
    reg o;
    begin
      so = 33'h0;
      step(1'b1, 1'b0, o);
      if (isir) step(1'b1, 1'b0, o);
      step(1'b0, 1'b0, o);
      step(1'b0, 1'b0, o);
      for (i = 0; i < n; i = i + 1) begin
        step(i == n - 1, din[i], o);
        so[i] = o;
      end
      step(1'b1, 1'b0, o);
      step(1'b0, 1'b0, o);
    end
  endtask
  task tap_reset;
    reg o;
    begin
      repeat (5) step(1'b1, 1'b0, o);
      step(1'b0, 1'b0, o);
    end
  endtask
  task ir(input [4:0] code);
    scan(1'b1, 5, {28'h0, code});
  endtask
  task dr(input integer n, input [32:0] din);
    scan(1'b0, n, din);
  endtask
  // control write, pending zero
  task ctl_write;
    begin
      ir(`INS_CONTROL);
      dr(32, {1'b0, keep_bits});
    end
  endtask
  // bounded poll for pending
  task poll;
    integer k;
    begin
      ir(`INS_CONTROL);
      for (k = 0; k < 20 && so[`CTL_PENDING] !== 1'b1; k = k + 1)
        dr(32, {1'b0, keep_bits | 32'h00040000});
    end
  endtask
  // read data, unused bytes zero
  task serve_read(input [31:0] d, input [1:0] sz);
    begin
      ir(`INS_DATA);
      dr(32, {1'b0, d & ~(32'hffffffff << (8 * sz + 8))});
      ctl_write;
    end
  endtask
  // take store data
  task serve_write;
    begin
      ir(`INS_DATA);
      dr(32, 33'h0);
      wr_word = so[31:0];
      ctl_write;
    end
  endtask
endmodule

// ===== dv/debug_probe_memory_access_tb_top.sv
// Purpose: bench for the probe access block
// Assumes: probe model on the test port
// Notes: inputs change 1 ns after ref_clk rises
`timescale 1ns/1ns
`include "debug_probe_map.vh"
module debug_probe_memory_access_tb_top;
  reg ref_clk = 1'b0, rst = 1'b1, cpu_req = 1'b0, cpu_write = 1'b0, cpu_fetch = 1'b0;
  reg debug_exception = 1'b0, soft_reset = 1'b0, debug_mode_flag = 1'b1;
  reg load_store_segment_select = 1'b1, ext_bus_idle = 1'b1;
  reg [31:0] cpu_addr = 32'h0, cpu_wdata = 32'h0, got = 32'h0;
  reg [1:0] cpu_size = 2'h0;
  wire tck, tms, tdi, tdo, cpu_stall, cpu_done, ext_bus_hold, probe_memory_enable, probe_vector_select;
  wire [31:0] cpu_rdata, fetch_instr, fetch_pc;
  integer err_total = 0, num_checks = 0, cycles = 0, done_cnt = 0, done_base = 0;
  debug_probe_memory_access u_dut (.*);
  probe_model u_probe (.*);
  ////////////////////////////////////////////////////////////////////////////////
  // clock, hang guard, completion catcher
  always #4 ref_clk = ~ref_clk;
  always @(posedge ref_clk) begin
    cycles = cycles + 1;
    if (cycles == 60000) begin
      err_total = err_total + 1;
      stop_test;
    end
  end
  // drop request on done
  always @(posedge ref_clk) begin
    #1;
    if (cpu_done === 1'b1) begin
      got = cpu_rdata;
      done_cnt = done_cnt + 1;
      cpu_req = 1'b0;
    end
  end
  ////////////////////////////////////////////////////////////////////////////////
  task chk(input [32:0] seen, input [32:0] exp);
    begin
      num_checks = num_checks + 1;
      if (seen !== exp) begin
        err_total = err_total + 1;
        $display("BAD %0t seen %h expected %h", $time, seen, exp);
      end
    end
  endtask
  task tick(input integer n);
    begin
      repeat (n) @(posedge ref_clk);
      #1;
    end
  endtask
  function [31:0] ctl(input d, input [1:0] s);
    ctl = u_probe.keep_bits | 32'h00040008 | {1'b0, s, 9'h0, d, 19'h0};
  endfunction
  task cpu_go(input [31:0] a, input w, input f, input [1:0] s, input [31:0] wd);
    begin
      tick(1);
      {cpu_addr, cpu_write, cpu_fetch, cpu_size, cpu_wdata} = {a, w, f, s, wd};
      done_base = done_cnt;
      cpu_req = 1'b1;
    end
  endtask
  task wait_done;
    integer k;
    begin
      for (k = 0; k < 80 && done_cnt == done_base; k = k + 1)
        tick(1);
      chk(done_cnt == done_base + 1, 1'b1);
    end
  endtask
  // probe reads control and address
  task access(input d, input [1:0] s, input [31:0] a);
    begin
      u_probe.poll;
      chk(u_probe.so, ctl(d, s));
      chk(cpu_stall & ext_bus_hold, 1'b1);
      u_probe.ir(`INS_ADDRESS);
      u_probe.dr(32, 33'h0);
      chk(u_probe.so, a);
    end
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  task s_reset_refuse;
    integer k;
    begin
      chk({cpu_stall, cpu_done, ext_bus_hold, probe_memory_enable, probe_vector_select}, 5'h0);
      u_probe.tap_reset;
      u_probe.ir(`INS_CONTROL);
      chk(u_probe.so, `IR_CAPTURE);
      u_probe.dr(32, 33'h0);
      chk(u_probe.so, 32'h8);
      cpu_go(32'hff200000, 1'b0, 1'b0, 2'h3, 32'h0);
      tick(20);
      chk(cpu_stall, 1'b0);
      cpu_req = 1'b0;
      u_probe.keep_bits = 32'h8000;
      u_probe.ctl_write;
      tick(4);
      chk(probe_memory_enable, 1'b1);
      for (k = 0; k < 3; k = k + 1) begin
        cpu_go(k == 0 ? 32'hff300000 : 32'hff2fffff, 1'b0, 1'b0, 2'h3, 32'h0);
        load_store_segment_select = k != 1;
        debug_mode_flag = k != 2;
        tick(10);
        chk(cpu_stall, 1'b0);
        cpu_req = 1'b0;
        load_store_segment_select = 1'b1;
        debug_mode_flag = 1'b1;
      end
    end
  endtask
  task s_load_store;
    begin
      cpu_go(32'hff200104, 1'b0, 1'b0, 2'h1, 32'h0);
      access(1'b0, 2'h1, 32'hff200104);
      u_probe.serve_read(32'h1234beef, 2'h1);
      wait_done;
      chk(got, 32'h0000beef);
      cpu_go(32'hff200008, 1'b1, 1'b0, 2'h3, 32'hcafe0001);
      access(1'b1, 2'h3, 32'hff200008);
      u_probe.serve_write;
      wait_done;
      chk(u_probe.wr_word, 32'hcafe0001);
    end
  endtask
  task s_fast;
    begin
      cpu_go(32'hff200004, 1'b0, 1'b0, 2'h3, 32'h0);
      u_probe.poll;
      u_probe.ir(`INS_FASTDATA);
      u_probe.dr(33, {32'h5a5a5a5a, 1'b1});
      chk(u_probe.so[0], 1'b1);
      tick(4);
      chk(ext_bus_hold & cpu_stall, 1'b1);
      u_probe.dr(33, {32'h76543210, 1'b0});
      chk(u_probe.so, {32'hcafe0001, 1'b1});
      wait_done;
      chk(got, 32'h76543210);
      cpu_go(32'hff20000c, 1'b1, 1'b0, 2'h3, 32'h600d0003);
      u_probe.poll;
      u_probe.ir(`INS_FASTDATA);
      u_probe.dr(33, 33'h0);
      chk(u_probe.so, {32'h600d0003, 1'b1});
      wait_done;
    end
  endtask
  task s_fail_abort;
    begin
      cpu_go(32'hff200010, 1'b0, 1'b0, 2'h3, 32'h0);
      u_probe.poll;
      u_probe.ir(`INS_FASTDATA);
      u_probe.dr(33, 33'h2);
      chk(u_probe.so[0], 1'b0);
      tick(4);
      chk(ext_bus_hold, 1'b1);
      soft_reset = 1'b1;
      cpu_req = 1'b0;
      tick(1);
      soft_reset = 1'b0;
      tick(3);
      chk({cpu_stall, ext_bus_hold, done_cnt == done_base}, 3'h1);
      u_probe.dr(33, 33'h0);
      chk(u_probe.so[0], 1'b0);
      u_probe.ctl_write;
      chk(u_probe.so[`CTL_PENDING], 1'b0);
    end
  endtask
  task s_serial_fetch;
    begin
      ext_bus_idle = 1'b0;
      cpu_go(32'hff200020, 1'b0, 1'b1, 2'h3, 32'h0);
      tick(20);
      chk({cpu_stall, ext_bus_hold}, 2'h2);
      ext_bus_idle = 1'b1;
      access(1'b0, 2'h3, 32'hff200020);
      u_probe.serve_read(32'h24080005, 2'h3);
      wait_done;
      chk(fetch_instr, 32'h24080005);
      chk(fetch_pc, 32'hff200024);
    end
  endtask
  task s_vector;
    begin
      u_probe.keep_bits = 32'hc000;
      u_probe.ctl_write;
      tick(4);
      chk(probe_vector_select, 1'b1);
      done_base = done_cnt;
      debug_exception = 1'b1;
      tick(1);
      debug_exception = 1'b0;
      access(1'b0, 2'h3, 32'hff200200);
      u_probe.serve_read(32'h3c1a0001, 2'h3);
      wait_done;
      chk(fetch_instr, 32'h3c1a0001);
      chk(fetch_pc, 32'hff200204);
    end
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  task stop_test;
    begin
      $display("checks %0d mismatches %0d", num_checks, err_total);
      if (err_total == 0 && num_checks > 0)
        $display("SIMULATION PASSED");
      else
        $display("SIMULATION FAILED");
      $finish;
    end
  endtask
  // run all scenarios
  initial begin
    repeat (5) @(posedge ref_clk);
    #1;
    rst = 1'b0;
    tick(1);
    s_reset_refuse;
    s_load_store;
    s_fast;
    s_fail_abort;
    s_serial_fetch;
    s_vector;
    stop_test;
  end
endmodule
